// ===== verilog/bmc_pkg.sv
// Purpose: Shared constants and types of the basic mode control block.
// Assumes: 125 MHz management clock, Avalon-MM slave with 32-bit data.
// Notes: Control register holds 16 bits in the low half of its word.
package bmc_pkg;

   // Register byte offsets
   localparam logic [3:0] BMC_CTRL_OFS = 4'h0;
   localparam logic [3:0] BMC_STAT_OFS = 4'h4;

   // Control register bit positions
   localparam int BMC_RST_BIT = 15;
   localparam int BMC_LOOP_BIT = 14;
   localparam int BMC_SPD_LO_BIT = 13;
   localparam int BMC_NEG_BIT = 12;
   localparam int BMC_SPD_HI_BIT = 6;

   // Control register values and masks
   localparam logic [15:0] BMC_CTRL_RESET = 16'h1140;
   localparam logic [15:0] BMC_CTRL_WMASK = 16'hF580;
   localparam logic [15:0] BMC_RST_MASK = 16'h8000;

   // Speed codes
   localparam logic [1:0] BMC_SPD_10 = 2'h0;
   localparam logic [1:0] BMC_SPD_100 = 2'h1;
   localparam logic [1:0] BMC_SPD_1000 = 2'h2;
   localparam logic [1:0] BMC_SPD_RSVD = 2'h3;

   // Status register bit positions
   localparam int BMC_ST_SPD_LO = 0;
   localparam int BMC_ST_NEG = 2;
   localparam int BMC_ST_BUSY = 3;
   localparam int BMC_ST_RSVD = 4;

   // Soft reset duration
   localparam int BMC_CLK_MHZ = 125;
   localparam int BMC_SOFT_RST_NS = 1000;
   localparam int BMC_SOFT_RST_CYC = (BMC_SOFT_RST_NS * BMC_CLK_MHZ + 999) / 1000;
   localparam logic [7:0] BMC_RST_LAST = 8'(BMC_SOFT_RST_CYC - 1);

   // MAC-side byte stream
   typedef struct packed {
      logic en;
      logic er;
      logic [7:0] data;
   } bmc_gmii_t;

   localparam bmc_gmii_t BMC_GMII_IDLE = '{en: 1'b0, er: 1'b0, data: 8'h00};

   // Avalon-MM request group
   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } bmc_avs_req_t;

   typedef enum logic [0:0] {BMC_BUS_IDLE, BMC_BUS_ACK} bmc_bus_state_t;

endpackage

// ===== verilog/bmc_soft_reset.sv
// Purpose: Times the soft reset of the management and interface logic.
// Assumes: go stays high until done has been seen by the owner.
// Notes: done is combinational so the owner clears its bit in the same edge.
`timescale 1ns/100ps
`default_nettype none
module bmc_soft_reset
   import bmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic go,
   output logic done
);

   typedef struct packed {
      logic [7:0] cnt;
   } bmc_srst_state_t;

   bmc_srst_state_t s_r;
   bmc_srst_state_t s_nxt;

   assign done = go && (s_r.cnt == BMC_RST_LAST);

   // Count while requested, restart from zero once finished
   always_comb begin
      s_nxt = s_r;
      if (!go || done) begin
         s_nxt.cnt = 8'h00;
      end else begin
         s_nxt.cnt = s_r.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   rst_count_a: assert property (go && !done |=> s_r.cnt == $past(s_r.cnt) + 8'h01)
      else $error("soft reset counter did not advance");

endmodule
`default_nettype wire

// ===== verilog/bmc_loopback.sv
// Purpose: Steers MAC transmit data to the line or back to the MAC.
// Assumes: Byte streams are synchronous to clk.
// Notes: Both paths add one register stage; line transmit idles in loopback.
`timescale 1ns/100ps
`default_nettype none
module bmc_loopback
   import bmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic loop_en,
   input wire logic hold,
   // Streams
   input wire bmc_gmii_t mac_tx,
   input wire bmc_gmii_t line_rx,
   output bmc_gmii_t mac_rx,
   output bmc_gmii_t line_tx
);

   typedef struct packed {
      bmc_gmii_t mac_rx;
      bmc_gmii_t line_tx;
   } bmc_loop_state_t;

   bmc_loop_state_t s_r;
   bmc_loop_state_t s_nxt;

   assign mac_rx = s_r.mac_rx;
   assign line_tx = s_r.line_tx;

   // Hold idles both paths so no half frame leaks during soft reset
   always_comb begin
      s_nxt = s_r;
      if (hold) begin
         s_nxt.mac_rx = BMC_GMII_IDLE;
         s_nxt.line_tx = BMC_GMII_IDLE;
      end else if (loop_en) begin
         s_nxt.mac_rx = mac_tx;
         s_nxt.line_tx = BMC_GMII_IDLE;
      end else begin
         s_nxt.mac_rx = line_rx;
         s_nxt.line_tx = mac_tx;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   loop_path_a: assert property (loop_en && !hold |=> mac_rx == $past(mac_tx))
      else $error("loopback did not return transmit data");

   loop_off_a: assert property (!loop_en && !hold |=> line_tx == $past(mac_tx) && mac_rx == $past(line_rx))
      else $error("normal path broken with loopback off");

endmodule
`default_nettype wire

// ===== verilog/bmc_top.sv
// Purpose: Basic mode control register with soft reset, loopback and speed.
// Assumes: Avalon-MM master holds its request until waitrequest is low.
// Notes: Every access answers after one wait cycle; unmapped reads give zero.
//
// Behaviour
// - Writing one to bit 15 runs a soft reset; bit clears itself when done.
// - Bit 14 set returns MAC transmit data to MAC receive path.
// - With negotiation off, bits 6 and 13 form the forced speed code.
// - Control register at offset zero, value 0x1140 after reset.
// - Hardware-updated fields show state set by the block's own logic.
// - Bit 12 enables negotiation, resets to one; forced code unused then.
// - Bit 6 is read-only one, so default forced code is 1000 Mb/s.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module bmc_top
   import bmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire bmc_avs_req_t avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Link state from the negotiation logic
   input wire logic [1:0] negotiated_speed,
   // Settings in effect
   output logic [1:0] speed_sel,
   output logic speed_reserved,
   output logic negotiation_enable,
   output logic soft_reset_busy,
   // MAC and line streams
   input wire bmc_gmii_t mac_tx,
   input wire bmc_gmii_t line_rx,
   output bmc_gmii_t mac_rx,
   output bmc_gmii_t line_tx
);

   localparam int RST_SPAN_A = BMC_SOFT_RST_CYC + 2;

   typedef struct packed {
      bmc_bus_state_t bus;
      logic waitreq;
      logic [31:0] rdata;
      logic [15:0] ctrl;
      logic [1:0] speed;
      logic spd_rsvd;
   } bmc_top_state_t;

   bmc_top_state_t s_r;
   bmc_top_state_t s_nxt;

   logic rst_done;
   logic req;
   logic commit;

   // Offset compare shared by read and write paths
   function automatic logic bmc_hit(input logic [3:0] addr, input logic [3:0] ofs);
      return addr == ofs;
   endfunction

   // Byte-lane merge; read-only bits keep their old value
   function automatic logic [15:0] bmc_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [15:0] m;
      m = old;
      if (be[0]) begin
         m[7:0] = wd[7:0];
      end
      if (be[1]) begin
         m[15:8] = wd[15:8];
      end
      return (m & BMC_CTRL_WMASK) | (old & ~BMC_CTRL_WMASK);
   endfunction

   // Read word for the status register, all live hardware state
   function automatic logic [31:0] bmc_status(input bmc_top_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[BMC_ST_SPD_LO +: 2] = s.speed;
      w[BMC_ST_NEG] = s.ctrl[BMC_NEG_BIT];
      w[BMC_ST_BUSY] = s.ctrl[BMC_RST_BIT];
      w[BMC_ST_RSVD] = s.spd_rsvd;
      return w;
   endfunction

   assign req = avs_req.read || avs_req.write;
   assign commit = (s_r.bus == BMC_BUS_ACK) && avs_req.write;

   // Output registers
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = s_r.waitreq;
   assign speed_sel = s_r.speed;
   assign speed_reserved = s_r.spd_rsvd;
   assign negotiation_enable = s_r.ctrl[BMC_NEG_BIT];
   assign soft_reset_busy = s_r.ctrl[BMC_RST_BIT];

   // Soft reset timer, driven by the self-clearing bit
   bmc_soft_reset u_srst (
      .clk(clk),
      .rst_n(rst_n),
      .go(s_r.ctrl[BMC_RST_BIT]),
      .done(rst_done)
   );

   // Loopback path, idled while the soft reset runs
   bmc_loopback u_loop (
      .clk(clk),
      .rst_n(rst_n),
      .loop_en(s_r.ctrl[BMC_LOOP_BIT]),
      .hold(s_r.ctrl[BMC_RST_BIT]),
      .mac_tx(mac_tx),
      .line_rx(line_rx),
      .mac_rx(mac_rx),
      .line_tx(line_tx)
   );

   // Bus handshake, register updates and speed resolution
   always_comb begin
      logic [15:0] m;
      logic [1:0] eff;
      m = 16'h0000;
      eff = BMC_SPD_10;
      s_nxt = s_r;

      // One wait cycle, then a single-cycle acknowledge
      case (s_r.bus)
         BMC_BUS_IDLE: begin
            if (req) begin
               s_nxt.bus = BMC_BUS_ACK;
               s_nxt.rdata = 32'h0000_0000;
               if (avs_req.read && bmc_hit(avs_req.address, BMC_CTRL_OFS)) begin
                  s_nxt.rdata = {16'h0000, s_r.ctrl};
               end else if (avs_req.read && bmc_hit(avs_req.address, BMC_STAT_OFS)) begin
                  s_nxt.rdata = bmc_status(s_r);
               end
            end
         end
         BMC_BUS_ACK: begin
            s_nxt.bus = BMC_BUS_IDLE;
         end
         default: begin
            s_nxt.bus = BMC_BUS_IDLE;
         end
      endcase
      s_nxt.waitreq = (s_nxt.bus != BMC_BUS_ACK);

      // Finished soft reset drops the bit; a write below may set it again
      if (rst_done) begin
         s_nxt.ctrl[BMC_RST_BIT] = 1'b0;
      end

      // Writes take effect only at the acknowledged edge
      if (commit && bmc_hit(avs_req.address, BMC_CTRL_OFS)) begin
         m = bmc_merge(s_r.ctrl, avs_req.writedata, avs_req.byteenable);
         if (m[BMC_RST_BIT]) begin
            // Soft reset returns every field to its reset value
            s_nxt.ctrl = BMC_CTRL_RESET | BMC_RST_MASK;
         end else if (!s_r.ctrl[BMC_RST_BIT]) begin
            // Writes during a running soft reset are dropped
            s_nxt.ctrl = m;
         end
      end

      // Forced code only while negotiation is off
      if (s_r.ctrl[BMC_NEG_BIT]) begin
         eff = negotiated_speed;
      end else begin
         eff = {s_r.ctrl[BMC_SPD_HI_BIT], s_r.ctrl[BMC_SPD_LO_BIT]};
      end
      s_nxt.speed = eff;
      s_nxt.spd_rsvd = (eff == BMC_SPD_RSVD);
   end

   // State register; reset value of the control word is fixed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r.bus <= BMC_BUS_IDLE;
         s_r.waitreq <= 1'b1;
         s_r.rdata <= 32'h0000_0000;
         s_r.ctrl <= BMC_CTRL_RESET;
         s_r.speed <= BMC_SPD_10;
         s_r.spd_rsvd <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   bus_ack_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");

   bus_ack_wait_a: assert property ($rose(req) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not acknowledged after one wait cycle");

   rst_self_clear_a: assert property ($rose(s_r.ctrl[BMC_RST_BIT]) |-> ##[1:RST_SPAN_A] !s_r.ctrl[BMC_RST_BIT])
      else $error("soft reset bit did not clear itself");

   rst_defaults_a: assert property (s_r.ctrl[BMC_RST_BIT] |-> (s_r.ctrl & ~BMC_RST_MASK) == BMC_CTRL_RESET)
      else $error("fields not at reset value during soft reset");

   ctrl_read_a: assert property (s_r.bus == BMC_BUS_ACK && avs_req.read
                                 && avs_req.address == BMC_CTRL_OFS && !s_r.ctrl[BMC_RST_BIT]
                                 |-> avs_readdata == {16'h0000, $past(s_r.ctrl)})
      else $error("control read data wrong");

   stat_live_a: assert property (s_r.bus == BMC_BUS_IDLE && avs_req.read
                                 && avs_req.address == BMC_STAT_OFS
                                 |=> avs_readdata[BMC_ST_BUSY] == $past(s_r.ctrl[BMC_RST_BIT])
                                 && avs_readdata[BMC_ST_SPD_LO +: 2] == $past(s_r.speed))
      else $error("status read does not show hardware state");

   loop_write_a: assert property (commit && avs_req.address == BMC_CTRL_OFS && avs_req.byteenable[1]
                                  && !s_r.ctrl[BMC_RST_BIT] && !avs_req.writedata[BMC_RST_BIT]
                                  |=> s_r.ctrl[BMC_LOOP_BIT] == $past(avs_req.writedata[BMC_LOOP_BIT]))
      else $error("loopback bit not written");

   forced_speed_a: assert property (!s_r.ctrl[BMC_NEG_BIT]
                                    |=> speed_sel == $past({s_r.ctrl[BMC_SPD_HI_BIT], s_r.ctrl[BMC_SPD_LO_BIT]}))
      else $error("forced speed code not applied");

   neg_speed_a: assert property (s_r.ctrl[BMC_NEG_BIT] |=> speed_sel == $past(negotiated_speed))
      else $error("negotiated speed not applied");

   msb_fixed_a: assert property (s_r.ctrl[BMC_SPD_HI_BIT])
      else $error("high speed bit not one");

   ro_bits_a: assert property ((s_r.ctrl & ~BMC_CTRL_WMASK) == (BMC_CTRL_RESET & ~BMC_CTRL_WMASK))
      else $error("read-only bits changed");

   // Soft reset loads defaults, idles streams and drops other writes
   rst_write_a: assert property (commit && avs_req.address == BMC_CTRL_OFS
                                 && avs_req.byteenable[1] && avs_req.writedata[BMC_RST_BIT]
                                 |=> s_r.ctrl == (BMC_CTRL_RESET | BMC_RST_MASK))
      else $error("soft reset write did not load the reset value");

   rst_drop_a: assert property (commit && avs_req.address == BMC_CTRL_OFS
                                && s_r.ctrl[BMC_RST_BIT] && !avs_req.writedata[BMC_RST_BIT] && !rst_done
                                |=> $stable(s_r.ctrl))
      else $error("write during soft reset changed the control word");

   rst_done_a: assert property (rst_done && !commit |=> !s_r.ctrl[BMC_RST_BIT])
      else $error("soft reset bit stayed set after the timer finished");

   rst_idle_a: assert property (s_r.ctrl[BMC_RST_BIT]
                                |=> mac_rx == BMC_GMII_IDLE && line_tx == BMC_GMII_IDLE)
      else $error("streams not idle during soft reset");

   // Loopback seen at the pins: line idle, MAC gets its own bytes back
   loop_idle_a: assert property (s_r.ctrl[BMC_LOOP_BIT] && !s_r.ctrl[BMC_RST_BIT]
                                 |=> line_tx == BMC_GMII_IDLE)
      else $error("line transmit not idle in loopback");

   loop_return_a: assert property (s_r.ctrl[BMC_LOOP_BIT] && !s_r.ctrl[BMC_RST_BIT]
                                   |=> mac_rx == $past(mac_tx))
      else $error("looped bytes not returned to the MAC");

   // Speed decode; bit 6 is always one, so with negotiation off a clear bit 13 means 1000 Mb/s
   rsvd_flag_a: assert property (speed_reserved == (speed_sel == BMC_SPD_RSVD))
      else $error("reserved flag disagrees with speed code");

   forced_rsvd_a: assert property (!s_r.ctrl[BMC_NEG_BIT] && s_r.ctrl[BMC_SPD_LO_BIT]
                                   |=> speed_reserved)
      else $error("forced code 3 not flagged reserved");

   forced_1000_a: assert property (!s_r.ctrl[BMC_NEG_BIT] && !s_r.ctrl[BMC_SPD_LO_BIT]
                                   |=> speed_sel == BMC_SPD_1000)
      else $error("default forced code is not 1000 Mb/s");

   spd_write_a: assert property (commit && avs_req.address == BMC_CTRL_OFS && avs_req.byteenable[1]
                                 && !s_r.ctrl[BMC_RST_BIT] && !avs_req.writedata[BMC_RST_BIT]
                                 |=> s_r.ctrl[BMC_SPD_LO_BIT] == $past(avs_req.writedata[BMC_SPD_LO_BIT]))
      else $error("low speed bit not written");

   neg_write_a: assert property (commit && avs_req.address == BMC_CTRL_OFS && avs_req.byteenable[1]
                                 && !s_r.ctrl[BMC_RST_BIT] && !avs_req.writedata[BMC_RST_BIT]
                                 |=> s_r.ctrl[BMC_NEG_BIT] == $past(avs_req.writedata[BMC_NEG_BIT]))
      else $error("negotiation enable bit not written");

   // Bus side: unmapped places, upper half zero, read data holds
   unmapped_read_a: assert property (s_r.bus == BMC_BUS_IDLE && avs_req.read
                                     && avs_req.address != BMC_CTRL_OFS && avs_req.address != BMC_STAT_OFS
                                     |=> avs_readdata == 32'h0000_0000)
      else $error("unmapped read did not return zero");

   unmapped_write_a: assert property (commit && avs_req.address != BMC_CTRL_OFS && !rst_done
                                      |=> $stable(s_r.ctrl))
      else $error("unmapped write changed the control word");

   upper_zero_a: assert property (avs_readdata[31:16] == 16'h0000)
      else $error("upper half of read data not zero");

   rdata_hold_a: assert property (!(s_r.bus == BMC_BUS_IDLE && req) |=> $stable(avs_readdata))
      else $error("read data changed without a new request");

   wait_idle_a: assert property (s_r.bus == BMC_BUS_IDLE && !req |=> avs_waitrequest)
      else $error("waitrequest low without a request");

   stat_upper_a: assert property (s_r.bus == BMC_BUS_IDLE && avs_req.read
                                  && avs_req.address == BMC_STAT_OFS |=> avs_readdata[31:5] == 27'h000_0000)
      else $error("unused status bits not zero");

endmodule
`default_nettype wire

// ===== verification/bmc_mac_model.sv
// Purpose: MAC transmit and line receive byte sources for the control block.
// Assumes: Both streams are synchronous to clk, no flow control.
// Notes: Payload changes every cycle so a stale or stuck path is visible.
`timescale 1ns/100ps
`default_nettype none
module bmc_mac_model
   import bmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Streams towards the block
   output var bmc_gmii_t mac_tx,
   output var bmc_gmii_t line_rx
);
   logic [7:0] cnt_r;

   // Distinct patterns so loopback cannot be confused with the line path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
         mac_tx <= BMC_GMII_IDLE;
         line_rx <= BMC_GMII_IDLE;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         mac_tx <= bmc_gmii_t'({cnt_r[1:0] != 2'h0, cnt_r[4:0] == 5'h1F, cnt_r});
         line_rx <= bmc_gmii_t'({~cnt_r[0], cnt_r[3:0] == 4'h5, ~cnt_r ^ 8'h5A});
      end
   end
endmodule
`default_nettype wire

// ===== verification/phy_basic_mode_control_reg_tb.sv
// Purpose: Self-checking bench of the basic mode control register block.
// Assumes: One wait cycle per bus access, but the bus task never relies on it.
// Notes: Table rows cover each speed code; soft reset and reset follow.
`timescale 1ns/100ps
`default_nettype none
module phy_basic_mode_control_reg_tb;
   import bmc_pkg::*;

   typedef struct packed {
      logic [15:0] wd;
      logic [1:0] nspd;
      logic [15:0] ctrl;
      logic [4:0] st;
   } bmc_row_t;

   logic clk;
   logic rst_n;
   bmc_avs_req_t avs_req;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] negotiated_speed;
   logic [1:0] speed_sel;
   logic speed_reserved;
   logic negotiation_enable;
   logic soft_reset_busy;
   bmc_gmii_t mac_tx, line_rx, mac_rx, line_tx;
   int mismatches;
   int num_checks;
   int n;
   logic [31:0] q;
   // Bit 6 always reads one, so forced codes are only 2 and 3
   bmc_row_t rows [5] = '{
      '{16'h0000, 2'h0, 16'h0040, 5'h02},
      '{16'h2000, 2'h0, 16'h2040, 5'h13},
      '{16'h1F3F, 2'h1, 16'h1540, 5'h05},
      '{16'h1080, 2'h0, 16'h10C0, 5'h04},
      '{16'h5000, 2'h2, 16'h5040, 5'h06}};

   bmc_top dut_u (.clk(clk), .rst_n(rst_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .negotiated_speed(negotiated_speed), .speed_sel(speed_sel),
      .speed_reserved(speed_reserved), .negotiation_enable(negotiation_enable),
      .soft_reset_busy(soft_reset_busy), .mac_tx(mac_tx), .line_rx(line_rx), .mac_rx(mac_rx),
      .line_tx(line_tx));

   bmc_mac_model mdl_u (.clk(clk), .rst_n(rst_n), .mac_tx(mac_tx), .line_rx(line_rx));

   // 125 MHz clock
   always #4 clk = ~clk;

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Request held until waitrequest is sampled low; bounded so a hang ends the run
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge clk);
      avs_req <= '{read: rd, write: !rd, address: a, writedata: d, byteenable: 4'hF};
      @(posedge clk);
      k = 1;
      while (avs_waitrequest !== 1'b0) begin
         if (k == 20) begin
            chk("bus_timeout", 32'h0000_0000, 32'h0000_0001);
            test_done();
         end
         @(posedge clk);
         k++;
      end
      r = avs_readdata;
      avs_req <= '0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b0, a, d, r);
   endtask

   // One cycle latency on both paths; old bytes sampled at the falling edge
   task automatic stream_chk(input logic lp);
      bmc_gmii_t tx_p, rx_p;
      repeat (4) begin
         @(negedge clk);
         tx_p = mac_tx;
         rx_p = line_rx;
         @(posedge clk);
         #1;
         chk("mac_rx", 32'(lp ? tx_p : rx_p), 32'(mac_rx));
         chk("line_tx", 32'(lp ? BMC_GMII_IDLE : tx_p), 32'(line_tx));
      end
   endtask

   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      avs_req = '0;
      negotiated_speed = 2'h0;
      mismatches = 0;
      num_checks = 0;
      repeat (19) @(posedge clk);
      chk("wait_rst", 32'h0000_0001, 32'(avs_waitrequest));
      chk("neg_rst", 32'h0000_0001, 32'(negotiation_enable));
      chk("mac_rx_rst", 32'h0000_0000, 32'(mac_rx));
      @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b1, BMC_CTRL_OFS, '0, q);
      chk("ctrl_reset", 32'h0000_1140, q);
      stream_chk(1'b0);
      // Each row: control write, readback, status and outputs in effect
      foreach (rows[i]) begin
         @(posedge clk);
         negotiated_speed <= rows[i].nspd;
         wr(BMC_CTRL_OFS, {16'h0000, rows[i].wd});
         bus(1'b1, BMC_CTRL_OFS, '0, q);
         chk("ctrl", {16'h0000, rows[i].ctrl}, q);
         bus(1'b1, BMC_STAT_OFS, '0, q);
         chk("status", {27'h0, rows[i].st}, q);
         chk("speed_sel", 32'(rows[i].st[1:0]), 32'(speed_sel));
         chk("speed_rsvd", 32'(rows[i].st[4]), 32'(speed_reserved));
         chk("neg_en", 32'(rows[i].st[2]), 32'(negotiation_enable));
      end
      // Unmapped places read zero and swallow writes
      bus(1'b1, 4'h8, '0, q);
      chk("unmapped", 32'h0000_0000, q);
      wr(4'hC, 32'h0000_FFFF);
      bus(1'b1, BMC_CTRL_OFS, '0, q);
      chk("ctrl_kept", 32'h0000_5040, q);
      stream_chk(1'b1);
      // Soft reset while loopback is on: streams idle, bit clears itself
      wr(BMC_CTRL_OFS, 32'h0000_C000);
      #1;
      n = 0;
      while (soft_reset_busy === 1'b1 && n < 300) begin
         // Return path still holds the last looped byte in the first busy cycle
         if (n > 0) begin
            chk("mac_rx_sr", 32'h0000_0000, 32'(mac_rx));
         end
         chk("line_tx_sr", 32'h0000_0000, 32'(line_tx));
         n++;
         @(posedge clk);
         #1;
      end
      chk("busy_len", 32'h0000_0001, 32'(n >= BMC_SOFT_RST_CYC && n <= BMC_SOFT_RST_CYC + 1));
      bus(1'b1, BMC_CTRL_OFS, '0, q);
      chk("ctrl_after_sr", 32'h0000_1140, q);
      stream_chk(1'b0);
      // Second reset in mid-run restores the reset value
      wr(BMC_CTRL_OFS, 32'h0000_2000);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk("speed_rst", 32'h0000_0000, 32'(speed_sel));
      rst_n <= 1'b1;
      bus(1'b1, BMC_CTRL_OFS, '0, q);
      chk("ctrl_rst2", 32'h0000_1140, q);
      test_done();
   end
endmodule
`default_nettype wire
